//--- pam_pkg.sv
// Package of constants and helper functions for the port A pin-function multiplexer.
package pam_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets on the APB slave
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFF_DIR = 12'h000;
  localparam logic [11:0] OFF_LATCH = 12'h004;
  localparam logic [11:0] OFF_READBACK = 12'h008;
  localparam logic [11:0] OFF_ALT_SEL = 12'h00C;
  localparam logic [11:0] OFF_PORT_FUNCTION_CTRL_REG = 12'h010;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int ALT_CH1A_BIT = 0;
  localparam int CS_EN_BIT = 0;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] ALT_RST = 8'h00;
  localparam logic [7:0] PORT_FUNCTION_CTRL_REG_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Pulse-unit and timer-connection codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] MD_NORMAL = 4'h0;
  localparam logic [1:0] MD_COMPARE_HI = 2'h1;
  localparam logic [3:0] MD_PWM1 = 4'h2;
  localparam logic [3:0] MD_PWM2 = 4'h3;
  localparam logic [1:0] IOA_CAPTURE_HI = 2'h2;
  localparam logic [1:0] CCLR_PWM2_OFF = 2'h1;
  localparam logic [1:0] SYNC_FEEDBACK = 2'h0;

  typedef logic [7:0] pam_byte_t;

  // Channel mode is normal (B'0000) or B'01xx: compare and capture both use it.
  function automatic logic pam_md_compare(input logic [3:0] md);
    return (md == MD_NORMAL) || (md[3:2] == MD_COMPARE_HI);
  endfunction

  // A-side I/O code whose low two bits are non-zero asks for an output.
  function automatic logic pam_ioa_drives(input logic [3:0] ioa);
    return ioa[1:0] != 2'h0;
  endfunction

endpackage

//--- pam_mux_if.sv
// Interface carrying control and pin signals between the top and its two mux slices.
`timescale 1ns/10ps
interface pam_mux_if;
  logic [7:0] dir;
  logic [7:0] latch;
  logic [7:0] pin_in;
  logic expanded, cs_en, alt_sel, cs_out, pulse_a_out;
  logic [3:0] md, ioa;
  logic [1:0] cclr, sync_mode;
  logic p7_out, p7_oe, pulse_a_in, ch1b_disable;
  logic cks_hi, cks_lo, cap_b_en, cap_c_en, cmp_b_en, cmp_b_out;
  logic clamp_en, clamp_val, blank_en, blank_val;
  logic [3:0] lo_out, lo_oe;
  logic ext_clk_in, cap_b_in, cap_c_in, hfb_in, vfb_in;

  modport ctl (output dir, latch, pin_in, expanded, cs_en, alt_sel, cs_out, pulse_a_out,
    md, ioa, cclr, sync_mode, cks_hi, cks_lo, cap_b_en, cap_c_en, cmp_b_en, cmp_b_out,
    clamp_en, clamp_val, blank_en, blank_val,
    input p7_out, p7_oe, pulse_a_in, ch1b_disable, lo_out, lo_oe,
    ext_clk_in, cap_b_in, cap_c_in, hfb_in, vfb_in);
  modport p7 (input dir, latch, pin_in, expanded, cs_en, alt_sel, cs_out, pulse_a_out,
    md, ioa, cclr, output p7_out, p7_oe, pulse_a_in, ch1b_disable);
  modport lo (input dir, latch, pin_in, sync_mode, cks_hi, cks_lo, cap_b_en, cap_c_en,
    cmp_b_en, cmp_b_out, clamp_en, clamp_val, blank_en, blank_val,
    output lo_out, lo_oe, ext_clk_in, cap_b_in, cap_c_in, hfb_in, vfb_in);
endinterface

//--- pam_pin7_mux.sv
// Function selection for pin 7: chip select, pulse-unit channel 1 A, or general I/O.
`timescale 1ns/10ps
module pam_pin7_mux (
  // Mux carrier
  pam_mux_if.p7 mx
);
  import pam_pkg::*;

  logic cmp_sel, pwm1_sel, pwm2_sel, cap_sel, pulse_drive;

  // Decode of the channel settings; nothing reaches the pin without the alternate select.
  always_comb begin
    cmp_sel = mx.alt_sel && pam_md_compare(mx.md) && !mx.ioa[3] && pam_ioa_drives(mx.ioa);
    pwm1_sel = mx.alt_sel && (mx.md == MD_PWM1) && pam_ioa_drives(mx.ioa);
    pwm2_sel = mx.alt_sel && (mx.md == MD_PWM2) && pam_ioa_drives(mx.ioa)
      && (mx.cclr != CCLR_PWM2_OFF);
    cap_sel = mx.alt_sel && pam_md_compare(mx.md) && (mx.ioa[3:2] == IOA_CAPTURE_HI);
    pulse_drive = cmp_sel || pwm1_sel || pwm2_sel;
  end

  // Chip select wins in expanded mode with its enable set; otherwise the pulse output overrides the direction.
  always_comb begin
    if (mx.expanded && mx.cs_en) begin
      mx.p7_out = mx.cs_out;
      mx.p7_oe = 1'b1;
    end else if (pulse_drive) begin
      mx.p7_out = mx.pulse_a_out;
      mx.p7_oe = 1'b1;
    end else begin
      mx.p7_out = mx.latch[7];
      mx.p7_oe = mx.dir[7];
    end
  end

  // Capture samples the pin even while chip select drives it.
  assign mx.pulse_a_in = cap_sel ? mx.pin_in[7] : 1'b0;
  // Channel B output is held off while channel A runs PWM mode 1.
  assign mx.ch1b_disable = pwm1_sel;

endmodule // pam_pin7_mux

//--- pam_pins_lo_mux.sv
// Function selection for pins 6 to 3: timer inputs, clamp, blanking and compare outputs.
`timescale 1ns/10ps
module pam_pins_lo_mux (
  // Mux carrier
  pam_mux_if.lo mx
);
  import pam_pkg::*;

  logic sync_fb;
  logic pin3_out, pin3_oe;

  assign sync_fb = (mx.sync_mode == SYNC_FEEDBACK);

  // Pins 6 and 5 stay general I/O; their peripheral taps only listen.
  assign mx.lo_out[3:2] = mx.latch[6:5];
  assign mx.lo_oe[3:2] = mx.dir[6:5];

  // Clamp output takes pin 4 regardless of the direction bit.
  assign mx.lo_out[1] = mx.clamp_en ? mx.clamp_val : mx.latch[4];
  assign mx.lo_oe[1] = mx.clamp_en | mx.dir[4];

  // Pin 3 priority: blanking, then compare B, then general I/O.
  // Local nets keep the process from sharing the carrier vector with the assigns.
  always_comb begin
    if (mx.blank_en) begin
      pin3_out = mx.blank_val;
      pin3_oe = 1'b1;
    end else if (mx.cmp_b_en) begin
      pin3_out = mx.cmp_b_out;
      pin3_oe = 1'b1;
    end else begin
      pin3_out = mx.latch[3];
      pin3_oe = mx.dir[3];
    end
  end

  assign mx.lo_out[0] = pin3_out;
  assign mx.lo_oe[0] = pin3_oe;

  // Inputs read the pin level in either direction; unrouted taps rest low.
  assign mx.ext_clk_in = (mx.cks_hi && mx.cks_lo) ? mx.pin_in[6] : 1'b0;
  assign mx.hfb_in = sync_fb ? mx.pin_in[6] : 1'b0;
  assign mx.cap_b_in = mx.cap_b_en ? mx.pin_in[5] : 1'b0;
  assign mx.vfb_in = sync_fb ? mx.pin_in[5] : 1'b0;
  assign mx.cap_c_in = mx.cap_c_en ? mx.pin_in[4] : 1'b0;

endmodule // pam_pins_lo_mux

//--- pam_port_a.sv
// Port A top: APB register file, pin readback and the upper-pin function multiplexer.
//
// Function
// - readback gives latch if output, else pin
// - readback register is read-only, writes ignored
// - readback has no reset value, follows pins
// - expanded mode with enable: pin 7 chip select
// - single-chip, no alternate: pin 7 general I/O
// - pulse function on pin 7 needs alternate select
// - compare settings drive compare output on pin 7
// - PWM modes drive pin 7, mode 2 not with counter clear 01; B output off in mode 1 only
// - capture settings route pin 7 to capture
// - chip-select enable lives in function control register
// - pin 6 general I/O, feeds timer clock
// - sync mode 00 routes pin 6 to horizontal
// - pin 5 general I/O, feeds capture B
// - sync mode 00 routes pin 5 to vertical
// - clamp enable drives clamp on pin 4
// - capture C enable routes pin 4 input
// - pin 3: blank, compare B, else I/O
// - direction bit 1 output, 0 input; resets 0
// - output latch read/write, resets to 0
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module pam_port_a (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire pam_pkg::pam_byte_t pin_in,
  output pam_pkg::pam_byte_t pin_out,
  output pam_pkg::pam_byte_t pin_oe,
  // Bus controller
  input wire logic expanded_bus_mode,
  input wire logic chip_select_out,
  // Pulse unit channel 1
  input wire logic [3:0] channel_mode_field,
  input wire logic [3:0] chan_a_io_control,
  input wire logic [1:0] counter_clear_select,
  input wire logic alt_pulse_ch1a_out,
  output logic alt_pulse_ch1a_in,
  output logic pulse_ch1b_out_disable,
  // Free-running timer 0
  input wire logic frt_clock_select_hi,
  input wire logic frt_clock_select_lo,
  input wire logic capture_b_irq_enable,
  input wire logic capture_c_irq_enable,
  input wire logic compare_b_out_enable,
  input wire logic frt_compare_b_out,
  output logic frt_ext_clock_in,
  output logic frt_capture_b_in,
  output logic frt_capture_c_in,
  // Timer connection
  input wire logic sync_input_mode_hi,
  input wire logic sync_input_mode_lo,
  input wire logic clamp_out_enable,
  input wire logic clamp_out,
  input wire logic blank_out_enable,
  input wire logic blanking_out,
  output logic horiz_feedback_in,
  output logic vert_feedback_in
);
  import pam_pkg::*;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  pam_byte_t dir_ff;
  pam_byte_t latch_ff;
  pam_byte_t alt_pin_select_reg_ff;
  pam_byte_t port_function_ctrl_reg_ff;
  logic [31:0] prdata_ff;
  pam_byte_t pin_readback_reg;
  logic wr_access, rd_setup, addr_mapped;

  pam_mux_if mx ();

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------

  // The slave never waits, so a write lands on the first access edge.
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // Only the five mapped words answer without error.
  always_comb begin
    unique case (paddr)
      OFF_DIR, OFF_LATCH, OFF_READBACK, OFF_ALT_SEL, OFF_PORT_FUNCTION_CTRL_REG: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_mapped;

  // ---------------------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------------------

  // Direction bits pick output or input while general I/O is selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= DIR_RST;
    end else if (wr_access && paddr == OFF_DIR) begin
      dir_ff <= pwdata[7:0];
    end
  end

  // Output latch holds the level for every pin used as a general output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= LATCH_RST;
    end else if (wr_access && paddr == OFF_LATCH) begin
      latch_ff <= pwdata[7:0];
    end
  end

  // Alternate pin select; only the channel 1 A bit is used by this port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_pin_select_reg_ff <= ALT_RST;
    end else if (wr_access && paddr == OFF_ALT_SEL) begin
      alt_pin_select_reg_ff <= pwdata[7:0];
    end
  end

  // Function control register carrying the pin 7 chip-select enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_function_ctrl_reg_ff <= PORT_FUNCTION_CTRL_REG_RST;
    end else if (wr_access && paddr == OFF_PORT_FUNCTION_CTRL_REG) begin
      port_function_ctrl_reg_ff <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Readback and read data
  // ---------------------------------------------------------------------------

  // Mixed value has no flops of its own, so it simply follows the pins after reset.
  assign pin_readback_reg = (dir_ff & latch_ff) | (~dir_ff & pin_in);

  // Read data is captured in the setup cycle so prdata is stable for the access cycle.
  // A write to the readback offset falls through every write decoder untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        OFF_DIR: prdata_ff <= {24'h00_0000, dir_ff};
        OFF_LATCH: prdata_ff <= {24'h00_0000, latch_ff};
        OFF_READBACK: prdata_ff <= {24'h00_0000, pin_readback_reg};
        OFF_ALT_SEL: prdata_ff <= {24'h00_0000, alt_pin_select_reg_ff};
        OFF_PORT_FUNCTION_CTRL_REG: prdata_ff <= {24'h00_0000, port_function_ctrl_reg_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_ff;

  // ---------------------------------------------------------------------------
  // Mux carrier wiring
  // ---------------------------------------------------------------------------
  assign mx.dir = dir_ff;
  assign mx.latch = latch_ff;
  assign mx.pin_in = pin_in;
  assign mx.expanded = expanded_bus_mode;
  assign mx.cs_en = port_function_ctrl_reg_ff[CS_EN_BIT];
  assign mx.alt_sel = alt_pin_select_reg_ff[ALT_CH1A_BIT];
  assign mx.cs_out = chip_select_out;
  assign mx.pulse_a_out = alt_pulse_ch1a_out;
  assign mx.md = channel_mode_field;
  assign mx.ioa = chan_a_io_control;
  assign mx.cclr = counter_clear_select;
  assign mx.sync_mode = {sync_input_mode_hi, sync_input_mode_lo};
  assign mx.cks_hi = frt_clock_select_hi;
  assign mx.cks_lo = frt_clock_select_lo;
  assign mx.cap_b_en = capture_b_irq_enable;
  assign mx.cap_c_en = capture_c_irq_enable;
  assign mx.cmp_b_en = compare_b_out_enable;
  assign mx.cmp_b_out = frt_compare_b_out;
  assign mx.clamp_en = clamp_out_enable;
  assign mx.clamp_val = clamp_out;
  assign mx.blank_en = blank_out_enable;
  assign mx.blank_val = blanking_out;

  // Pin 7 slice.
  pam_pin7_mux u_pin7 (
    .mx(mx.p7)
  );

  // Pins 6 to 3 slice.
  pam_pins_lo_mux u_pins_lo (
    .mx(mx.lo)
  );

  // ---------------------------------------------------------------------------
  // Pin and peripheral outputs
  // ---------------------------------------------------------------------------

  // Lower three pins are plain I/O here; their own functions sit elsewhere.
  assign pin_out = {mx.p7_out, mx.lo_out, latch_ff[2:0]};
  assign pin_oe = {mx.p7_oe, mx.lo_oe, dir_ff[2:0]};
  assign alt_pulse_ch1a_in = mx.pulse_a_in;
  assign pulse_ch1b_out_disable = mx.ch1b_disable;
  assign frt_ext_clock_in = mx.ext_clk_in;
  assign frt_capture_b_in = mx.cap_b_in;
  assign frt_capture_c_in = mx.cap_c_in;
  assign horiz_feedback_in = mx.hfb_in;
  assign vert_feedback_in = mx.vfb_in;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic single_gpio7;
  assign single_gpio7 = !(expanded_bus_mode && port_function_ctrl_reg_ff[CS_EN_BIT])
    && !alt_pin_select_reg_ff[ALT_CH1A_BIT];

  sequence s_rb_setup;
    psel && !penable && !pwrite && paddr == OFF_READBACK;
  endsequence

  sequence s_rb_write;
    psel && penable && pwrite && paddr == OFF_READBACK;
  endsequence

  a_readback_mix: assert property (s_rb_setup |=> prdata[7:0] ==
      (($past(dir_ff) & $past(latch_ff)) | (~$past(dir_ff) & $past(pin_in))))
    else $error("readback value does not mix latch and pin by direction");

  a_readback_ro: assert property (s_rb_write |=> $stable(dir_ff) && $stable(latch_ff)
      && $stable(alt_pin_select_reg_ff) && $stable(port_function_ctrl_reg_ff))
    else $error("write to readback changed register state");

  a_latch_write: assert property (wr_access && paddr == OFF_LATCH
      |=> latch_ff == $past(pwdata[7:0]) ##1 $stable(latch_ff) || wr_access)
    else $error("output latch write not stored");

  a_dir_output: assert property (single_gpio7 |-> pin_oe[7] == dir_ff[7]
      && pin_out[7] == latch_ff[7])
    else $error("pin 7 not general I/O in single-chip mode");

  a_cs_drive: assert property (expanded_bus_mode && port_function_ctrl_reg_ff[CS_EN_BIT]
      |-> pin_oe[7] && pin_out[7] == chip_select_out)
    else $error("pin 7 not driving chip select");

  a_pulse_gate: assert property (!alt_pin_select_reg_ff[ALT_CH1A_BIT]
      |-> !alt_pulse_ch1a_in && !pulse_ch1b_out_disable)
    else $error("pulse function reached pin 7 without alternate select");

  a_compare_drive: assert property (alt_pin_select_reg_ff[ALT_CH1A_BIT]
      && !expanded_bus_mode && channel_mode_field == MD_NORMAL
      && chan_a_io_control == 4'h5 |-> pin_oe[7] && pin_out[7] == alt_pulse_ch1a_out)
    else $error("compare output not on pin 7");

  a_pwm2_block: assert property (alt_pin_select_reg_ff[ALT_CH1A_BIT] && !expanded_bus_mode
      && channel_mode_field == MD_PWM2 && counter_clear_select == CCLR_PWM2_OFF
      |-> pin_oe[7] == dir_ff[7])
    else $error("PWM mode 2 drove pin 7 with blocked counter clear");

  a_capture_route: assert property (alt_pin_select_reg_ff[ALT_CH1A_BIT]
      && channel_mode_field == 4'h4 && chan_a_io_control[3:2] == IOA_CAPTURE_HI
      |-> alt_pulse_ch1a_in == pin_in[7])
    else $error("pin 7 not routed to capture input");

  a_frt_clock: assert property (frt_clock_select_hi && frt_clock_select_lo
      |-> frt_ext_clock_in == pin_in[6] && pin_oe[6] == dir_ff[6])
    else $error("pin 6 not feeding timer clock");

  a_sync_feedback: assert property (!sync_input_mode_hi && !sync_input_mode_lo
      |-> horiz_feedback_in == pin_in[6] && vert_feedback_in == pin_in[5])
    else $error("sync feedback inputs not routed");

  a_capture_b: assert property (capture_b_irq_enable |-> frt_capture_b_in == pin_in[5])
    else $error("pin 5 not feeding capture B");

  a_clamp_drive: assert property (clamp_out_enable |-> pin_oe[4] && pin_out[4] == clamp_out)
    else $error("clamp output not on pin 4");

  a_capture_c: assert property (capture_c_irq_enable |-> frt_capture_c_in == pin_in[4])
    else $error("pin 4 not feeding capture C");

  a_blank_first: assert property (blank_out_enable
      |-> pin_oe[3] && pin_out[3] == blanking_out)
    else $error("blanking output lost priority on pin 3");

  a_pin3_gpio: assert property (!blank_out_enable && !compare_b_out_enable
      |-> pin_oe[3] == dir_ff[3] && pin_out[3] == latch_ff[3])
    else $error("pin 3 not following its direction bit");

  a_reset_dir: assert property ($rose(presetn) |-> dir_ff == DIR_RST && latch_ff == LATCH_RST)
    else $error("direction or latch not cleared by reset");

endmodule // pam_port_a

//--- pam_board_model.sv
// Board-side model of the port A pins: free pins show the board level, driven pins the device.
`timescale 1ns/10ps
module pam_board_model (
  // Board side
  input wire logic [7:0] board_level,
  // Device pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in
);
  // A driven pin reads back the device's value, so a board fight can never hide a fault.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule // pam_board_model

//--- pam_port_a_tb_top.sv
// Self-checking testbench for the port A pin-function multiplexer.
`timescale 1ns/10ps
module pam_port_a_tb_top;
  import pam_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pam_byte_t pin_in, pin_out, pin_oe, board;
  logic expanded_bus_mode, chip_select_out, alt_pulse_ch1a_out, alt_pulse_ch1a_in;
  logic pulse_ch1b_out_disable, frt_clock_select_hi, frt_clock_select_lo;
  logic [3:0] channel_mode_field, chan_a_io_control;
  logic [1:0] counter_clear_select;
  logic capture_b_irq_enable, capture_c_irq_enable, compare_b_out_enable, frt_compare_b_out;
  logic frt_ext_clock_in, frt_capture_b_in, frt_capture_c_in, sync_input_mode_hi;
  logic sync_input_mode_lo, clamp_out_enable, clamp_out, blank_out_enable, blanking_out;
  logic horiz_feedback_in, vert_feedback_in;
  int miscompares, checked;

  // Design and board model.
  pam_port_a i_pam_port_a (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .expanded_bus_mode,
    .chip_select_out, .channel_mode_field, .chan_a_io_control, .counter_clear_select,
    .alt_pulse_ch1a_out, .alt_pulse_ch1a_in, .pulse_ch1b_out_disable, .frt_clock_select_hi,
    .frt_clock_select_lo, .capture_b_irq_enable, .capture_c_irq_enable, .compare_b_out_enable,
    .frt_compare_b_out, .frt_ext_clock_in, .frt_capture_b_in, .frt_capture_c_in,
    .sync_input_mode_hi, .sync_input_mode_lo, .clamp_out_enable, .clamp_out,
    .blank_out_enable, .blanking_out, .horiz_feedback_in, .vert_feedback_in);
  pam_board_model i_pam_board_model (.board_level(board), .pin_out, .pin_oe, .pin_in);

  // 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask

  // Set the pulse unit, then check pin 7's enable and, when driven, its value.
  task automatic p7(input logic [3:0] md, input logic [3:0] io, input logic [1:0] cc,
                    input logic eoe, input logic eout);
    @(posedge pclk);
    channel_mode_field <= md;
    chan_a_io_control <= io;
    counter_clear_select <= cc;
    #1;
    chk(32'(pin_oe[7]), 32'(eoe));
    if (eoe) begin
      chk(32'(pin_out[7]), 32'(eout));
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Readback mixes latch and pin; pin 4 is forced by clamp so latch and pin disagree.
  task automatic t_regs();
    chk(32'(pin_oe), 32'h0);
    apb(1'b0, OFF_LATCH, 32'h0);
    chk(rd, 32'h0);
    @(posedge pclk);
    clamp_out_enable <= 1'b1;
    clamp_out <= 1'b1;
    board <= 8'hA4;
    apb(1'b1, OFF_DIR, 32'h11);
    apb(1'b1, OFF_LATCH, 32'h01);
    apb(1'b0, OFF_READBACK, 32'h0);
    chk(rd, 32'h11 & 32'h01 | ~32'h11 & 32'hB5 & 32'hFF);
    @(posedge pclk);
    board <= 8'h5A;
    apb(1'b0, OFF_READBACK, 32'h0);
    chk(rd, 32'h01 | 32'hEE & 32'h5B);
    apb(1'b1, OFF_READBACK, 32'hFF);
    chk(32'(err), 32'h0);
    apb(1'b1, 12'h020, 32'hFF);
    apb(1'b0, 12'h020, 32'h0);
    chk(32'({err, rd[7:0]}), 32'h100);
    apb(1'b0, OFF_LATCH, 32'h0);
    chk(rd, 32'h01);
    apb(1'b0, OFF_DIR, 32'h0);
    chk(rd, 32'h11);
  endtask

  // Pin 7 through general I/O, compare, PWM, capture and chip select.
  task automatic t_pin7();
    apb(1'b1, OFF_DIR, 32'h80);
    apb(1'b1, OFF_LATCH, 32'h80);
    p7(4'h0, 4'h1, 2'h0, 1'b1, 1'b1);
    apb(1'b1, OFF_DIR, 32'h00);
    p7(4'h0, 4'h1, 2'h0, 1'b0, 1'b0);
    apb(1'b1, OFF_ALT_SEL, 32'h01);
    p7(4'h0, 4'h1, 2'h0, 1'b1, 1'b0);
    p7(4'h6, 4'h7, 2'h0, 1'b1, 1'b0);
    p7(4'h0, 4'h4, 2'h0, 1'b0, 1'b0);
    @(posedge pclk);
    alt_pulse_ch1a_out <= 1'b1;
    p7(4'h2, 4'hD, 2'h0, 1'b1, 1'b1);
    chk(32'(pulse_ch1b_out_disable), 32'h1);
    p7(4'h3, 4'h2, 2'h1, 1'b0, 1'b0);
    p7(4'h3, 4'h2, 2'h0, 1'b1, 1'b1);
    @(posedge pclk);
    board <= 8'h80;
    p7(4'h5, 4'h9, 2'h0, 1'b0, 1'b0);
    chk(32'(alt_pulse_ch1a_in), 32'h1);
    @(posedge pclk);
    board <= 8'h00;
    p7(4'h0, 4'hA, 2'h0, 1'b0, 1'b0);
    chk(32'(alt_pulse_ch1a_in), 32'h0);
    apb(1'b1, OFF_DIR, 32'h80);
    #1;
    chk(32'(alt_pulse_ch1a_in), 32'h1);
    apb(1'b1, OFF_PORT_FUNCTION_CTRL_REG, 32'h01);
    expanded_bus_mode <= 1'b1;
    chip_select_out <= 1'b0;
    p7(4'h0, 4'h8, 2'h0, 1'b1, 1'b0);
    chk(32'(alt_pulse_ch1a_in), 32'h0);
    p7(4'h2, 4'h1, 2'h0, 1'b1, 1'b0);
    apb(1'b1, OFF_PORT_FUNCTION_CTRL_REG, 32'h00);
    p7(4'h2, 4'h1, 2'h0, 1'b1, 1'b1);
  endtask

  // Mid-run reset must clear direction, latch and the select bits driving pin 7.
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(pin_oe[7]), 32'h0);
    apb(1'b0, OFF_LATCH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFF_DIR, 32'h0);
    chk(rd, 32'h0);
  endtask

  // Pins 6 to 3: timer taps, feedback inputs, clamp, blanking and compare outputs.
  task automatic t_lo();
    apb(1'b1, OFF_DIR, 32'h00);
    @(posedge pclk);
    clamp_out_enable <= 1'b0;
    board <= 8'h70;
    {frt_clock_select_hi, frt_clock_select_lo} <= 2'h3;
    {capture_b_irq_enable, capture_c_irq_enable} <= 2'h3;
    #1;
    chk(32'({frt_ext_clock_in, frt_capture_b_in, frt_capture_c_in}), 32'h7);
    chk(32'({horiz_feedback_in, vert_feedback_in}), 32'h3);
    @(posedge pclk);
    {frt_clock_select_hi, frt_clock_select_lo} <= 2'h2;
    {sync_input_mode_hi, sync_input_mode_lo} <= 2'h1;
    capture_b_irq_enable <= 1'b0;
    clamp_out_enable <= 1'b1;
    clamp_out <= 1'b0;
    #1;
    chk(32'({frt_ext_clock_in, frt_capture_b_in}), 32'h0);
    chk(32'({horiz_feedback_in, vert_feedback_in}), 32'h0);
    chk(32'({pin_oe[4], pin_out[4], frt_capture_c_in}), 32'h4);
    @(posedge pclk);
    {blank_out_enable, blanking_out, compare_b_out_enable, frt_compare_b_out} <= 4'hE;
    #1;
    chk(32'({pin_oe[3], pin_out[3]}), 32'h3);
    @(posedge pclk);
    blank_out_enable <= 1'b0;
    #1;
    chk(32'({pin_oe[3], pin_out[3]}), 32'h2);
    @(posedge pclk);
    compare_b_out_enable <= 1'b0;
    clamp_out_enable <= 1'b0;
    #1;
    chk(32'({pin_oe[3], pin_oe[4]}), 32'h0);
    @(posedge pclk);
    {frt_clock_select_hi, frt_clock_select_lo} <= 2'h3;
    apb(1'b1, OFF_LATCH, 32'h00);
    apb(1'b1, OFF_DIR, 32'h40);
    #1;
    chk(32'({pin_oe[6], pin_out[6], frt_ext_clock_in}), 32'h4);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, board} = '0;
    {expanded_bus_mode, chip_select_out, alt_pulse_ch1a_out, channel_mode_field} = '0;
    {chan_a_io_control, counter_clear_select, frt_clock_select_hi, frt_clock_select_lo} = '0;
    {capture_b_irq_enable, capture_c_irq_enable, compare_b_out_enable, frt_compare_b_out} = '0;
    {sync_input_mode_hi, sync_input_mode_lo, clamp_out_enable, clamp_out} = '0;
    {blank_out_enable, blanking_out} = '0;
    miscompares = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_regs();
    t_pin7();
    t_reset();
    t_lo();
    print_verdict();
  end
endmodule // pam_port_a_tb_top
